// *** design/hsir_evt_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Carries live status to the flag latch and the latched flags back
interface hsir_evt_if;
    import hsir_pkg::*;
    logic [HSIR_NUM_EVT-1:0] status;
    logic                    clr;
    logic                    soft_rst;
    logic [HSIR_NUM_EVT-1:0] flags;
    modport ctrl (output status, output clr, output soft_rst, input flags);
    modport latch(input status, input clr, input soft_rst, output flags);
endinterface

`default_nettype wire

// *** design/hsir_flag_latch.sv ***
`timescale 1ns/10ps
`default_nettype none

module hsir_flag_latch (
    input  wire logic  clk,   // Core clock
    input  wire logic  rst_n, // Async reset, active low
    hsir_evt_if.latch  evt    // Status in, flags out
);
    import hsir_pkg::*;

    logic [HSIR_NUM_EVT-1:0] flag_r;
    logic [HSIR_NUM_EVT-1:0] flag_nxt;

    // ****************************************
    // Sticky flags, one per status bit
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < HSIR_NUM_EVT; g++) begin : g_flag
            // Set wins over the read clear so no event is lost
            always_comb begin
                if (evt.soft_rst) begin
                    flag_nxt[g] = HSIR_FLAG_RESET[g];
                end else if (evt.status[g]) begin
                    flag_nxt[g] = 1'b1; // R7 R8 R9 R10 R11 R12 R13 R19
                end else if (evt.clr) begin
                    flag_nxt[g] = 1'b0; // R7
                end else begin
                    flag_nxt[g] = flag_r[g];
                end
            end
        end
    endgenerate

    // Register the flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= HSIR_FLAG_RESET;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign evt.flags = flag_r;

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
        (evt.clr && !evt.soft_rst && evt.status[HSIR_BIT_UVOLT])
        |=> flag_r[HSIR_BIT_UVOLT]) // R19
        else $error("event lost during flag read");

endmodule

`default_nettype wire

// *** design/hsir_pkg.sv ***
package hsir_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] HSIR_ADDR_SOFT_RESET = 8'h00; // soft_reset_trigger
    localparam logic [7:0] HSIR_ADDR_STATUS     = 8'h01; // live_condition_status
    localparam logic [7:0] HSIR_ADDR_FLAGS      = 8'h02; // latched_event_flags
    localparam logic [7:0] HSIR_ADDR_MASKS      = 8'h03; // event_pin_masks

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int         HSIR_BIT_DONE  = 0;
    localparam int         HSIR_BIT_OTEMP = 1;
    localparam int         HSIR_BIT_OCUR  = 2;
    localparam int         HSIR_BIT_AFULL = 3;
    localparam int         HSIR_BIT_AEMPT = 4;
    localparam int         HSIR_BIT_UVOLT = 5;
    localparam int         HSIR_NUM_EVT   = 6;

    localparam logic [7:0] HSIR_SOFTWARE_RESET_CODE = 8'hAA;
    localparam logic [5:0] HSIR_FLAG_RESET          = 6'h10;
    localparam logic [7:0] HSIR_MASK_RESET          = 8'hFF;

    typedef struct packed {
        logic       wr;    // Write strobe, one cycle
        logic       rd;    // Read strobe, one cycle
        logic [7:0] addr;  // Register address
        logic [7:0] wdata; // Write data
    } hsir_req_t;

endpackage

// *** design/hsir_regs.sv ***
// Functional notes
// R1 - Writing AA to the reset register restores all configuration defaults.
// R2 - Status bit 5 shows battery under-voltage live.
// R3 - Status bit 2 shows over-current live, resets to 0.
// R4 - Status bit 1 shows over-temperature live, resets to 0.
// R5 - Status bit 0 shows playback finished, resets to 0.
// R6 - Host never writes reserved registers.
// R7 - Flags latch status since last read; reading clears; bits 7:6 unused.
// R8 - Flag 4 latches almost-empty; status and flag reset to 1.
// R9 - Flag 3 latches almost-full; status and flag reset to 0.
// R10 - Flag 5 latches any under-voltage since last read.
// R11 - Flag 0 latches any playback-finished since last read.
// R12 - Flag 2 latches any over-current since last read.
// R13 - Flag 1 latches any over-temperature since last read.
// R14 - Mask 5 gates under-voltage flag onto interrupt pin; resets to 1.
// R15 - Mask 4 gates almost-empty flag; resets 1; mask bits 7:6 reset 3.
// R16 - Mask 3 gates almost-full flag; resets to 1.
// R17 - Masks 2,1,0 gate over-current, over-temp, done flags; reset 1.
// R18 - Interrupt low while any flag set with its mask clear.
// R19 - Event in the read cycle stays set while older flags clear.
`timescale 1ns/10ps
`default_nettype none

module hsir_regs
    import hsir_pkg::*;
(
    input  wire logic            ref_clk,                    // Core clock, 100 MHz
    input  wire logic            rst_n,                      // Async reset, active low
    input  wire hsir_pkg::hsir_req_t req,                    // Register bus request
    output logic [7:0]           rdata,                      // Read data, registered
    output logic                 rvalid,                     // Read data valid pulse
    input  wire logic            undervoltage_status,        // Battery below 2.7 V
    input  wire logic            buffer_almost_empty_status, // Stream buffer nearly empty
    input  wire logic            buffer_almost_full_status,  // Stream buffer nearly full
    input  wire logic            overcurrent_status,         // Over-current present
    input  wire logic            overtemp_status,            // Over-temperature present
    input  wire logic            playback_done_status,       // Playback finished
    output logic                 soft_reset_pulse,           // Config reset pulse to other blocks
    output logic                 irq_out_low                 // Interrupt, active low
);
    import hsir_pkg::*;

    hsir_evt_if evt ();

    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;
    logic       srst_r;
    logic       srst_nxt;
    logic       irq_n_r;
    logic       irq_n_nxt;
    logic [5:0] status_w;
    logic       soft_hit;

    // ****************************************
    // Live status collection
    // ****************************************
    always_comb begin
        status_w                 = '0;
        status_w[HSIR_BIT_UVOLT] = undervoltage_status;        // R2
        status_w[HSIR_BIT_AEMPT] = buffer_almost_empty_status; // R8
        status_w[HSIR_BIT_AFULL] = buffer_almost_full_status;  // R9
        status_w[HSIR_BIT_OCUR]  = overcurrent_status;         // R3
        status_w[HSIR_BIT_OTEMP] = overtemp_status;            // R4
        status_w[HSIR_BIT_DONE]  = playback_done_status;       // R5
    end

    // Soft reset only on the exact code; other values are ignored
    assign soft_hit     = req.wr && (req.addr == HSIR_ADDR_SOFT_RESET)
                          && (req.wdata == HSIR_SOFTWARE_RESET_CODE); // R1
    assign evt.status   = status_w;
    assign evt.clr      = req.rd && (req.addr == HSIR_ADDR_FLAGS);   // R7
    assign evt.soft_rst = soft_hit;

    hsir_flag_latch u_latch (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .evt   (evt)
    );

    // ****************************************
    // Register access next state
    // ****************************************
    always_comb begin
        mask_nxt   = mask_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        srst_nxt   = soft_hit;
        if (soft_hit) begin
            mask_nxt = HSIR_MASK_RESET; // R1 R15
        end else if (req.wr && req.addr == HSIR_ADDR_MASKS) begin
            mask_nxt = req.wdata; // R14 R15 R16 R17
        end
        // Writes to status or flags have no effect; host must not rely on it
        if (req.rd) begin
            rvalid_nxt = 1'b1;
            case (req.addr)
                HSIR_ADDR_STATUS: rdata_nxt = {2'b00, status_w};     // R2 R3 R4 R5
                HSIR_ADDR_FLAGS:  rdata_nxt = {2'b00, evt.flags};    // R7
                HSIR_ADDR_MASKS:  rdata_nxt = mask_r;
                default:          rdata_nxt = 8'h00; // Reset reg is write-only
            endcase
        end
    end

    // ****************************************
    // Interrupt pin
    // ****************************************
    // Uses registered flags so the pin follows the latch by one cycle
    always_comb begin
        irq_n_nxt = ~|(evt.flags & ~mask_r[5:0]); // R14 R15 R16 R17 R18
    end

    // Registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r   <= HSIR_MASK_RESET;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            srst_r   <= 1'b0;
            irq_n_r  <= 1'b1;
        end else begin
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            srst_r   <= srst_nxt;
            irq_n_r  <= irq_n_nxt;
        end
    end

    assign rdata            = rdata_r;
    assign rvalid           = rvalid_r;
    assign soft_reset_pulse = srst_r;
    assign irq_out_low      = irq_n_r;

    // ****************************************
    // Checks
    // ****************************************
    AST_SOFT_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_hit |=> (mask_r == HSIR_MASK_RESET) && soft_reset_pulse) // R1
        else $error("soft reset did not restore masks");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|(evt.flags & ~mask_r[5:0])) |=> !irq_out_low) // R18
        else $error("interrupt not asserted");
    AST_IRQ_REL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|(evt.flags & ~mask_r[5:0])) |=> irq_out_low) // R18
        else $error("interrupt not released");
    AST_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (evt.clr && !soft_hit && status_w == 6'h00) |=> evt.flags == 6'h00) // R7
        else $error("flag read did not clear");
    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (overcurrent_status && !soft_hit) |=> evt.flags[HSIR_BIT_OCUR]) // R12
        else $error("over-current not latched");
    AST_STATUS_RD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == HSIR_ADDR_STATUS)
        |=> rvalid && rdata == {2'b00, $past(status_w)}) // R2
        else $error("status read mismatch");
    AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.wr && req.addr == HSIR_ADDR_MASKS) |=> mask_r == $past(req.wdata)) // R16
        else $error("mask write lost");
    AST_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (&mask_r[5:0]) |=> irq_out_low) // R17
        else $error("masked flag drove interrupt");

    COV_IRQ:   cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(irq_out_low));
    COV_SRST:  cover property (@(posedge ref_clk) disable iff (!rst_n) soft_hit);
    COV_RACE:  cover property (@(posedge ref_clk) disable iff (!rst_n) evt.clr && |status_w);

endmodule

`default_nettype wire

// *** verif/haptic_status_interrupt_regs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module haptic_status_interrupt_regs_bench;
    import hsir_pkg::*;
    logic       ref_clk, rst_n, rvalid, srp, irq, v;
    logic [5:0] st;
    logic [7:0] rdata, d, lf;
    hsir_req_t  req;
    int         failures, checks, cyc, pulses, mflags;

    hsir_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .undervoltage_status(st[5]), .buffer_almost_empty_status(st[4]),
        .buffer_almost_full_status(st[3]), .overcurrent_status(st[2]),
        .overtemp_status(st[1]), .playback_done_status(st[0]),
        .soft_reset_pulse(srp), .irq_out_low(irq));
    hsir_host_model u_host (.ref_clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    // ****************************************
    // Clock, timeout and pulse counting
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pulses <= pulses + int'(srp === 1'b1);
        if (cyc == 6000) begin
            failures++;
            conclude();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Read and compare, valid pulse included
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask
    // Raise some status lines for two cycles, then drop them
    task automatic pulse(input logic [5:0] s);
        st <= s;
        repeat (2) @(negedge ref_clk);
        st <= 6'h00;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {failures, checks, cyc, pulses} = '0;
        rst_n = 1'b0;
        st = 6'h10;
        lf = 8'd78;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        rchk(HSIR_ADDR_STATUS, 8'h10);
        rchk(HSIR_ADDR_MASKS, 8'hFF);
        check({7'h00, irq}, 8'h01);
        rchk(HSIR_ADDR_FLAGS, 8'h10);
        rchk(8'h7F, 8'h00);
        st = 6'h00;
        rchk(HSIR_ADDR_FLAGS, 8'h10);
        rchk(HSIR_ADDR_FLAGS, 8'h00);
        $display("reset test done");
        // Each flag latches a short event and clears on read
        for (int i = 0; i < HSIR_NUM_EVT; i++) begin
            pulse(6'(1 << i));
            rchk(HSIR_ADDR_FLAGS, 8'(1 << i));
            rchk(HSIR_ADDR_FLAGS, 8'h00);
        end
        $display("latch test done");
        // Live status follows random conditions, flags gather them all
        mflags = 0;
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            st <= lf[5:0];
            mflags |= lf[5:0];
            rchk(HSIR_ADDR_STATUS, {2'b00, lf[5:0]});
        end
        st <= 6'h00;
        rchk(HSIR_ADDR_FLAGS, 8'(mflags));
        rchk(HSIR_ADDR_FLAGS, 8'h00);
        $display("status test done");
        // Each mask gates only its own flag onto the pin
        for (int i = 0; i < HSIR_NUM_EVT; i++) begin
            pulse(6'(1 << i));
            check({7'h00, irq}, 8'h01);
            u_host.wr(HSIR_ADDR_MASKS, ~8'(1 << i));
            repeat (2) @(negedge ref_clk);
            check({7'h00, irq}, 8'h00);
            rchk(HSIR_ADDR_MASKS, ~8'(1 << i));
            rchk(HSIR_ADDR_FLAGS, 8'(1 << i));
            repeat (2) @(negedge ref_clk);
            check({7'h00, irq}, 8'h01);
        end
        $display("mask test done");
        // Event held through a read stays latched
        st <= 6'h01;
        rchk(HSIR_ADDR_FLAGS, 8'h01);
        rchk(HSIR_ADDR_FLAGS, 8'h01);
        st <= 6'h00;
        rchk(HSIR_ADDR_FLAGS, 8'h01);
        rchk(HSIR_ADDR_FLAGS, 8'h00);
        $display("overlap test done");
        // Only the exact code restores defaults
        u_host.wr(HSIR_ADDR_MASKS, 8'h00);
        u_host.wr(HSIR_ADDR_SOFT_RESET, 8'h55);
        rchk(HSIR_ADDR_MASKS, 8'h00);
        pulse(6'h04);
        u_host.wr(HSIR_ADDR_SOFT_RESET, HSIR_SOFTWARE_RESET_CODE);
        rchk(HSIR_ADDR_MASKS, 8'hFF);
        rchk(HSIR_ADDR_FLAGS, 8'h10);
        check({7'h00, irq}, 8'h01);
        check(8'(pulses), 8'h01);
        $display("soft reset test done");
        conclude();
    end
endmodule

`default_nettype wire

// *** verif/hsir_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Host on the register bus, changes the request only at falling edges
module hsir_host_model
    import hsir_pkg::*;
(
    input  wire logic           ref_clk, // Core clock
    input  wire logic [7:0]     rdata,   // Read data
    input  wire logic           rvalid,  // Read valid pulse
    output var  hsir_req_t      req      // Request to device
);
    // Bus starts all zero; between transfers it shows inverted address, with inverted data after a write and FF after a read, so stale values never match
    initial req = '0;

    // One write, one cycle wide; only mapped registers are written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // One read; answer is taken once the valid pulse has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = rdata;
        v = rvalid;
    endtask
endmodule

`default_nettype wire
